// file: bench/gci_chk.sv
// concurrent checks on the global clock injection top ports
`timescale 1ns/1ps
module gci_chk (
   input wire logic CORE_CLK,
   input wire logic ARST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [3:0] GLOBAL_MESH_NET,
   input wire logic [15:0] FABRIC_TAP_INPUT
);
   logic run_reg;
   logic [3:0] used_reg;
   wire acc = PSEL && PENABLE;
   wire rd_acc = acc && !PWRITE;
   wire sel_adr = PADDR inside {8'h04, 8'h08, 8'h10, 8'h14};
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         run_reg <= 1'h0;
         used_reg <= 4'h0;
      end else if (acc && PWRITE && !PSLVERR && PADDR == 8'h00) begin
         run_reg <= PWDATA[0];
         used_reg <= PWDATA[7:4];
      end
   end
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!ARST_N);
   ready_zero_wait_a: assert property (PREADY == acc)
      else $error("pready off access phase");
   unmapped_err_a: assert property (acc && PADDR > 8'h18 |-> PSLVERR)
      else $error("unmapped access accepted");
   status_ro_a: assert property (acc && PWRITE && PADDR == 8'h18 |-> PSLVERR)
      else $error("status write accepted");
   static_sel_a: assert property (acc && PWRITE && run_reg && sel_adr |-> PSLVERR)
      else $error("selector write while running");
   ctrl_open_a: assert property (acc && PADDR == 8'h00 |-> !PSLVERR)
      else $error("control access refused");
   ctrl_read_a: assert property (rd_acc && PADDR == 8'h00 |->
      PRDATA == {24'h0, used_reg, 3'h0, run_reg}) else $error("control readback wrong");
   status_read_a: assert property (rd_acc && PADDR == 8'h18 |->
      PRDATA[8] == run_reg && PRDATA[6:4] == 3'($countones(used_reg))) else $error("status wrong");
   unused_net_a: assert property ($stable(used_reg) [*2] |-> (GLOBAL_MESH_NET & ~used_reg) == 4'h0)
      else $error("net driven without buffer cell");
   idle_taps_a: assert property ((!run_reg) [*3] |-> FABRIC_TAP_INPUT == 16'h0)
      else $error("taps active while stopped");
   refuse_c: cover property (acc && PSLVERR);
   mesh_c: cover property (run_reg && GLOBAL_MESH_NET != 4'h0);
   taps_c: cover property (FABRIC_TAP_INPUT != 16'h0);
endmodule
bind gci_top gci_chk u_chk (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .GLOBAL_MESH_NET(GLOBAL_MESH_NET), .FABRIC_TAP_INPUT(FABRIC_TAP_INPUT));

// file: bench/gci_fab_model.sv
// model of the external clock sources and the user fabric logic
`timescale 1ns/1ps
module gci_fab_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic slow,
   output logic [3:0] pins,
   output logic serdes,
   output logic [3:0] fref,
   output logic [3:0] fglob
);
   logic [7:0] cnt_reg = 8'h00;
   logic half_reg = 1'h0;
   // sources step every cycle, or every other cycle when slow
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= 8'h00;
         half_reg <= 1'h0;
      end else begin
         half_reg <= ~half_reg;
         if (!slow || half_reg) begin
            cnt_reg <= cnt_reg + 8'h01;
         end
      end
   end
   assign pins = cnt_reg[4:1];
   assign serdes = cnt_reg[0];
   assign fref = ~cnt_reg[3:0];
   assign fglob = cnt_reg[7:4] ^ cnt_reg[3:0];
endmodule

// file: bench/tb.sv
// self-checking bench for the global clock injection block
`timescale 1ns/1ps
module tb;
   typedef struct packed {
      logic [31:0] insel;
      logic [31:0] pllref;
      logic [31:0] pllcfg;
      logic [31:0] meshsel;
      logic [15:0] bits;
      logic [7:0] dly;
      logic [3:0] inv;
   } gci_row_s;
   // settings beside each net's expected history bit, depth and inversion
   gci_row_s rows [4] = '{'{32'h3210, 32'h0123, 32'h0, 32'h3424_1404, 16'h0123, 8'hff, 4'h0},
      '{32'hb38c, 32'h3210, 32'h0, 32'h3424_1404, 16'h3304, 8'hff, 4'hb},
      '{32'h3210, 32'h3210, 32'h0, 32'h0506_0708, 16'h5678, 8'h00, 4'h0},
      '{32'h3210, 32'h3210, 32'h8888, 32'h3424_1404, 16'hcba9, 8'h55, 4'h0}};
   logic [31:0] rst_tab [7] = '{gci_pkg::RST_CTRL, gci_pkg::RST_INSEL, gci_pkg::RST_PLLREF, gci_pkg::RST_PLLCFG,
      gci_pkg::RST_PLLDIV, gci_pkg::RST_MESHSEL, 32'h0};
   logic core_clk = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, slow = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, serdes;
   logic [3:0] pins, fref, fglob, mesh;
   logic [15:0] taps;
   logic [12:0] hist [4];
   int failures = 0, cmp_count = 0, cycles = 0;
   gci_top dut (.CORE_CLK(core_clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .DEDICATED_CLOCK_PIN(pins), .SERDES_CLOCK_INPUT(serdes), .FABRIC_REFERENCE_CLOCK(fref),
      .FABRIC_GLOBAL_SOURCE(fglob), .GLOBAL_MESH_NET(mesh), .FABRIC_TAP_INPUT(taps));
   gci_fab_model u_fab (.clk(core_clk), .arst_n(arst_n), .slow(slow), .pins(pins), .serdes(serdes),
      .fref(fref), .fglob(fglob));
   always #50 core_clk = ~core_clk;
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
      output logic err);
      @(posedge core_clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      @(posedge core_clk);
      while (pready !== 1'h1) begin
         @(posedge core_clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // source history and run limit
   always @(posedge core_clk) begin
      hist[0] <= {fref, fglob, serdes, pins};
      for (int k = 1; k < 4; k++) begin
         hist[k] <= hist[k - 1];
      end
      cycles++;
      if (cycles == 5000) begin
         failures++;
         final_report();
      end
   end
   initial begin
      logic [31:0] rd;
      logic err;
      logic [3:0] exp;
      int n;
      repeat (3) @(posedge core_clk);
      arst_n <= 1'h1;
      for (int i = 0; i < 4; i++) begin
         apb(1'h1, 8'h00, 32'h0, rd, err);
         apb(1'h1, 8'h04, rows[i].insel, rd, err);
         apb(1'h1, 8'h08, rows[i].pllref, rd, err);
         apb(1'h1, 8'h0c, rows[i].pllcfg, rd, err);
         apb(1'h1, 8'h14, rows[i].meshsel, rd, err);
         apb(1'h1, 8'h00, 32'hf1, rd, err);
         check(32'(err), 32'h0);
         repeat (6) @(posedge core_clk);
         repeat (16) begin
            @(negedge core_clk);
            for (int k = 0; k < 4; k++) begin
               exp[k] = hist[rows[i].dly[2*k+:2]][rows[i].bits[4*k+:4]] ^ rows[i].inv[k];
            end
            check(32'(mesh), 32'(exp));
         end
         $display("row %0d done", i);
      end
      apb(1'h1, 8'h04, 32'h1111, rd, err);
      check(32'(err), 32'h1);
      apb(1'h0, 8'h04, 32'h0, rd, err);
      check(rd, 32'h3210);
      apb(1'h1, 8'h18, 32'h0, rd, err);
      check(32'(err), 32'h1);
      apb(1'h0, 8'h1c, 32'h0, rd, err);
      check(rd, 32'h0);
      apb(1'h0, 8'h18, 32'h0, rd, err);
      check(rd, 32'h140);
      $display("refusal done");
      apb(1'h1, 8'h00, 32'h1, rd, err);
      repeat (4) @(posedge core_clk);
      repeat (8) begin
         @(negedge core_clk);
         check(32'(mesh), 32'h0);
      end
      $display("unused mesh done");
      slow <= 1'h1;
      apb(1'h1, 8'h00, 32'h0, rd, err);
      apb(1'h1, 8'h0c, 32'h153, rd, err);
      apb(1'h1, 8'h08, 32'h3410, rd, err);
      apb(1'h1, 8'h00, 32'h1, rd, err);
      n = 0;
      repeat (20) begin
         @(negedge core_clk);
         check(32'(taps[3:0]), 32'h0);
         if (taps[7:4] != 4'h0) n++;
      end
      check(32'(n > 0), 32'h1);
      n = 0;
      while (taps[3:0] === 4'h0 && n < 300) begin
         @(negedge core_clk);
         n++;
      end
      apb(1'h0, 8'h18, 32'h0, rd, err);
      check(32'(rd[3:0]), 32'h1);
      repeat (16) begin
         @(negedge core_clk);
         check(32'({taps[0] ^ taps[2], taps[1] ^ taps[3], taps[6] ^ taps[7]}), 32'h7);
      end
      $display("lock and phases done");
      @(posedge core_clk);
      arst_n <= 1'h0;
      repeat (3) @(posedge core_clk);
      check(32'({mesh, taps}), 32'h0);
      arst_n <= 1'h1;
      for (int i = 0; i < 7; i++) begin
         apb(1'h0, 8'(4 * i), 32'h0, rd, err);
         check(rd, rst_tab[i]);
      end
      $display("reset done");
      final_report();
   end
endmodule

// file: shared/gci_pkg.sv
// shared constants and carrier types of the global clock injection block
package gci_pkg;
   localparam int NUM_PIN = 5;
   localparam int NUM_REF = 4;
   localparam int NUM_PLL = 4;
   localparam int NUM_NET = 4;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_INSEL = 8'h04;
   localparam logic [7:0] ADDR_PLLREF = 8'h08;
   localparam logic [7:0] ADDR_PLLCFG = 8'h0c;
   localparam logic [7:0] ADDR_PLLDIV = 8'h10;
   localparam logic [7:0] ADDR_MESHSEL = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   // field positions
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_USE_LSB = 4;
   localparam int INSEL_INV_BIT = 3;
   localparam int PLLREF_FAB_BIT = 2;
   localparam int PLLCFG_EN_BIT = 0;
   localparam int PLLCFG_LOCKREQ_BIT = 1;
   localparam int PLLCFG_DBL_BIT = 2;
   localparam int PLLCFG_BYPFAB_BIT = 3;
   localparam int MESHSEL_PLL_LSB = 4;
   localparam int STATUS_LOCK_LSB = 0;
   localparam int STATUS_USED_LSB = 4;
   localparam int STATUS_RUN_BIT = 8;
   // reset values
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam logic [31:0] RST_INSEL = 32'h0000_3210;
   localparam logic [31:0] RST_PLLREF = 32'h0000_3210;
   localparam logic [31:0] RST_PLLCFG = 32'h0000_0000;
   localparam logic [31:0] RST_PLLDIV = 32'h0101_0101;
   localparam logic [31:0] RST_MESHSEL = 32'h3020_1000;
   // input selector source codes: 0..3 pins, 4 serdes input
   localparam logic [2:0] SRC_SERDES = 3'h4;
   // mesh selector source codes
   localparam logic [3:0] MSRC_BYPASS = 4'h4;
   localparam logic [3:0] MSRC_USER0 = 4'h5;
   localparam logic [3:0] MSRC_USER3 = 4'h8;
   // reference edges seen before the loop reports lock
   localparam logic [3:0] LOCK_REF_EDGES = 4'h8;

   typedef struct packed {
      logic en;
      logic lock_req;
      logic dbl;
      logic byp_fab;
      logic ref_fab;
      logic [1:0] ref_idx;
      logic [7:0] div;
   } gci_pll_cfg_s;

   typedef struct packed {
      logic [3:0] phase;
      logic bypass;
   } gci_pll_out_s;
endpackage

// file: src/gci_mesh_sel.sv
// selector for one mesh net: loop phases, bypass or a fabric source
`timescale 1ns/1ps
module gci_mesh_sel (
   input gci_pkg::gci_pll_out_s pll_out [4],
   input wire logic [3:0] fab_src,
   input wire logic [7:0] sel,
   input wire logic used,
   output logic net
);
   logic [3:0] code;
   gci_pkg::gci_pll_out_s pick;
   logic raw;

   assign code = sel[3:0];
   assign pick = pll_out[sel[gci_pkg::MESHSEL_PLL_LSB +: 2]];
   // wrapper signals or fabric signals, clocks or not
   assign raw = (code < gci_pkg::MSRC_BYPASS) ? pick.phase[code[1:0]] :
                (code == gci_pkg::MSRC_BYPASS) ? pick.bypass :
                (code <= gci_pkg::MSRC_USER3) ? fab_src[2'(code - gci_pkg::MSRC_USER0)] : 1'b0;
   // a net with no buffer cell behind it stays idle
   assign net = used & raw;
endmodule

// file: src/gci_pll_wrap.sv
// one loop wrapper: reference choice, lock, gated quadrature outputs, bypass
`timescale 1ns/1ps
module gci_pll_wrap (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic run,
   input gci_pkg::gci_pll_cfg_s cfg,
   input wire logic [3:0] ref_sel_clk,
   input wire logic ref_fab_clk,
   output gci_pkg::gci_pll_out_s out,
   output logic locked
);
   logic ref_clk;
   logic byp_clk;
   logic ref_d_reg;
   logic ref_rise;
   logic [3:0] lock_cnt_reg;
   logic [7:0] div_cnt_reg;
   logic tick;
   logic [1:0] ph_reg;
   logic gate;
   logic [3:0] ph;
   gci_pkg::gci_pll_out_s out_reg;
   gci_pkg::gci_pll_out_s out_next;

   // exactly one reference per loop
   assign ref_clk = cfg.ref_fab ? ref_fab_clk : ref_sel_clk[cfg.ref_idx];
   // either input passes unmodified around the loop
   assign byp_clk = cfg.byp_fab ? ref_fab_clk : ref_sel_clk[cfg.ref_idx];
   assign ref_rise = ref_clk & ~ref_d_reg;
   assign locked = (lock_cnt_reg == gci_pkg::LOCK_REF_EDGES);
   assign tick = cfg.en & run & (div_cnt_reg == 8'h00);
   // four quarter-period phases, doubled rate on the upper two
   assign ph[0] = ~ph_reg[1];
   assign ph[1] = ph_reg[1] ^ ph_reg[0];
   assign ph[2] = cfg.dbl ? ph_reg[0] : ph_reg[1];
   assign ph[3] = cfg.dbl ? ~ph_reg[0] : ~(ph_reg[1] ^ ph_reg[0]);
   // enable and optional wait for lock
   assign gate = cfg.en & run & (~cfg.lock_req | locked);
   assign out_next.phase = gate ? ph : 4'h0;
   assign out_next.bypass = run & byp_clk;
   assign out = out_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ref_d_reg <= 1'b0;
         lock_cnt_reg <= 4'h0;
         div_cnt_reg <= 8'h00;
         ph_reg <= 2'h0;
         out_reg <= '0;
      end else begin
         ref_d_reg <= ref_clk;
         if (!(cfg.en & run)) begin
            lock_cnt_reg <= 4'h0;
         end else if (ref_rise && !locked) begin
            lock_cnt_reg <= lock_cnt_reg + 4'h1;
         end
         div_cnt_reg <= tick || !(cfg.en & run) ? cfg.div : div_cnt_reg - 8'h01;
         if (tick) begin
            ph_reg <= ph_reg + 2'h1;
         end
         out_reg <= out_next;
      end
   end
endmodule

// file: src/gci_top.sv
// global clock injection: input selector, four loop wrappers, mesh selectors, apb registers
//
// Overview of operation
// - five input clocks routed to four reference outputs
// - each reference output may be inverted
// - four wrappers, any reference usable by any
// - one reference per loop, selector or fabric
// - loop output in four quarter phases
// - output enable, lock required, upper-phase doubling
// - either input clock bypasses the loop
// - wrapper phase outputs, not the bypass, also reach fabric taps
// - mesh nets pick wrapper or fabric signals
// - fabric sources may be any high-fanout signal
// - exactly four low-skew mesh nets
// - no buffer cell leaves mesh unused
`timescale 1ns/1ps
module gci_top (
   input wire logic CORE_CLK,
   input wire logic ARST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [3:0] DEDICATED_CLOCK_PIN,
   input wire logic SERDES_CLOCK_INPUT,
   input wire logic [3:0] FABRIC_REFERENCE_CLOCK,
   input wire logic [3:0] FABRIC_GLOBAL_SOURCE,
   output logic [3:0] GLOBAL_MESH_NET,
   output logic [15:0] FABRIC_TAP_INPUT
);
   // register file
   logic [31:0] ctrl_reg;
   logic [31:0] insel_reg;
   logic [31:0] pllref_reg;
   logic [31:0] pllcfg_reg;
   logic [31:0] plldiv_reg;
   logic [31:0] meshsel_reg;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;

   // bus decode
   logic setup;
   logic access;
   logic wr;
   logic hit_ctrl;
   logic hit_insel;
   logic hit_pllref;
   logic hit_pllcfg;
   logic hit_plldiv;
   logic hit_meshsel;
   logic hit_status;
   logic mapped;
   logic locked_cfg;
   logic refused;
   logic wr_ok;

   // pin synchronisers
   logic [4:0] pin_meta_reg;
   logic [4:0] pin_sync_reg;

   // datapath
   logic run;
   logic [3:0] mesh_used;
   logic [3:0] ref_clk;
   logic [3:0] lock;
   logic [2:0] used_count;
   logic [31:0] status;
   logic [3:0] mesh_next;
   logic [3:0] mesh_reg;
   logic [15:0] tap_next;
   logic [15:0] tap_reg;
   gci_pkg::gci_pll_cfg_s pll_cfg [4];
   gci_pkg::gci_pll_out_s pll_out [4];

   // pick one of the five synchronised input clocks
   function automatic logic pick_pin(input logic [2:0] src, input logic [4:0] pins);
      logic r;
      r = 1'b0;
      if (src <= gci_pkg::SRC_SERDES) begin
         r = pins[src];
      end
      return r;
   endfunction

   // true when a write addresses one of the selector settings
   function automatic logic is_selector(input logic [7:0] a);
      return (a == gci_pkg::ADDR_INSEL) || (a == gci_pkg::ADDR_PLLREF) ||
             (a == gci_pkg::ADDR_PLLDIV) || (a == gci_pkg::ADDR_MESHSEL);
   endfunction

   // ---------------------------------------------------------------- apb slave
   assign setup = PSEL & ~PENABLE;
   assign access = PSEL & PENABLE;
   assign wr = access & PWRITE;
   assign hit_ctrl = (PADDR == gci_pkg::ADDR_CTRL);
   assign hit_insel = (PADDR == gci_pkg::ADDR_INSEL);
   assign hit_pllref = (PADDR == gci_pkg::ADDR_PLLREF);
   assign hit_pllcfg = (PADDR == gci_pkg::ADDR_PLLCFG);
   assign hit_plldiv = (PADDR == gci_pkg::ADDR_PLLDIV);
   assign hit_meshsel = (PADDR == gci_pkg::ADDR_MESHSEL);
   assign hit_status = (PADDR == gci_pkg::ADDR_STATUS);
   assign mapped = hit_ctrl | hit_insel | hit_pllref | hit_pllcfg | hit_plldiv | hit_meshsel | hit_status;
   // selector settings are static while the clocks run
   assign locked_cfg = run & is_selector(PADDR);
   assign refused = ~mapped | (PWRITE & (hit_status | locked_cfg));
   assign wr_ok = wr & ~refused;
   assign PREADY = access;
   assign PSLVERR = access & refused;
   assign PRDATA = prdata_reg;

   always_comb begin
      prdata_next = prdata_reg;
      if (setup) begin
         case (1'b1)
            hit_ctrl: prdata_next = ctrl_reg;
            hit_insel: prdata_next = insel_reg;
            hit_pllref: prdata_next = pllref_reg;
            hit_pllcfg: prdata_next = pllcfg_reg;
            hit_plldiv: prdata_next = plldiv_reg;
            hit_meshsel: prdata_next = meshsel_reg;
            hit_status: prdata_next = status;
            default: prdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl_reg <= gci_pkg::RST_CTRL;
         insel_reg <= gci_pkg::RST_INSEL;
         pllref_reg <= gci_pkg::RST_PLLREF;
         pllcfg_reg <= gci_pkg::RST_PLLCFG;
         plldiv_reg <= gci_pkg::RST_PLLDIV;
         meshsel_reg <= gci_pkg::RST_MESHSEL;
         prdata_reg <= 32'h0000_0000;
      end else begin
         prdata_reg <= prdata_next;
         if (wr_ok && hit_ctrl) begin
            ctrl_reg <= PWDATA & 32'h0000_00f1;
         end
         if (wr_ok && hit_insel) begin
            insel_reg <= PWDATA & 32'h0000_ffff;
         end
         if (wr_ok && hit_pllref) begin
            pllref_reg <= PWDATA & 32'h0000_7777;
         end
         if (wr_ok && hit_pllcfg) begin
            pllcfg_reg <= PWDATA & 32'h0000_ffff;
         end
         if (wr_ok && hit_plldiv) begin
            plldiv_reg <= PWDATA;
         end
         if (wr_ok && hit_meshsel) begin
            meshsel_reg <= PWDATA & 32'h3f3f_3f3f;
         end
      end
   end

   // ---------------------------------------------------------------- control and status
   assign run = ctrl_reg[gci_pkg::CTRL_RUN_BIT];
   assign mesh_used = ctrl_reg[gci_pkg::CTRL_USE_LSB +: 4];
   // count of nets that carry a buffer cell; at most four by construction
   assign used_count = 3'(mesh_used[0]) + 3'(mesh_used[1]) + 3'(mesh_used[2]) + 3'(mesh_used[3]);

   always_comb begin
      status = 32'h0000_0000;
      status[gci_pkg::STATUS_LOCK_LSB +: 4] = lock;
      status[gci_pkg::STATUS_USED_LSB +: 3] = used_count;
      status[gci_pkg::STATUS_RUN_BIT] = run;
   end

   // ---------------------------------------------------------------- pin synchronisers
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pin_meta_reg <= 5'h00;
         pin_sync_reg <= 5'h00;
      end else begin
         pin_meta_reg <= {SERDES_CLOCK_INPUT, DEDICATED_CLOCK_PIN};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // ---------------------------------------------------------------- input selector and wrappers
   genvar g;
   generate
      for (g = 0; g < gci_pkg::NUM_REF; g++) begin : g_ref
         // any of five inputs, optionally inverted, per output
         assign ref_clk[g] = pick_pin(insel_reg[4*g +: 3], pin_sync_reg) ^ insel_reg[4*g + gci_pkg::INSEL_INV_BIT];
      end

      for (g = 0; g < gci_pkg::NUM_PLL; g++) begin : g_pll
         assign pll_cfg[g].en = pllcfg_reg[4*g + gci_pkg::PLLCFG_EN_BIT];
         assign pll_cfg[g].lock_req = pllcfg_reg[4*g + gci_pkg::PLLCFG_LOCKREQ_BIT];
         assign pll_cfg[g].dbl = pllcfg_reg[4*g + gci_pkg::PLLCFG_DBL_BIT];
         assign pll_cfg[g].byp_fab = pllcfg_reg[4*g + gci_pkg::PLLCFG_BYPFAB_BIT];
         assign pll_cfg[g].ref_fab = pllref_reg[4*g + gci_pkg::PLLREF_FAB_BIT];
         assign pll_cfg[g].ref_idx = pllref_reg[4*g +: 2];
         assign pll_cfg[g].div = plldiv_reg[8*g +: 8];

         // every reference reaches every wrapper
         gci_pll_wrap u_wrap (
            .clk(CORE_CLK),
            .arst_n(ARST_N),
            .run(run),
            .cfg(pll_cfg[g]),
            .ref_sel_clk(ref_clk),
            .ref_fab_clk(FABRIC_REFERENCE_CLOCK[g]),
            .out(pll_out[g]),
            .locked(lock[g])
         );

         // phases also go to the fabric tap inputs
         assign tap_next[4*g +: 4] = pll_out[g].phase;
      end

      for (g = 0; g < gci_pkg::NUM_NET; g++) begin : g_net
         // one selector per mesh net, four nets in all
         gci_mesh_sel u_sel (
            .pll_out(pll_out),
            .fab_src(FABRIC_GLOBAL_SOURCE),
            .sel(meshsel_reg[8*g +: 8]),
            .used(mesh_used[g]),
            .net(mesh_next[g])
         );
      end
   endgenerate

   // ---------------------------------------------------------------- output stage
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mesh_reg <= 4'h0;
         tap_reg <= 16'h0000;
      end else begin
         mesh_reg <= mesh_next;
         tap_reg <= tap_next;
      end
   end

   assign GLOBAL_MESH_NET = mesh_reg;
   assign FABRIC_TAP_INPUT = tap_reg;
endmodule
